// ---- core/fbp_top.sv ----
// Top of the flash block protection logic.
// Assumes fetch, data and debug ports are arbitrated upstream: one read a cycle.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - A 128 KB flash array is reachable by instruction and data paths.
// - The array erases in 1 KB units, each independently of others.
// - A finished erase leaves every bit in the unit at one.
// - Protection applies per 2 KB unit of two erase units, each set alone.
// - Read-only units refuse every erase and program request.
// - Execute-only units refuse every erase and program request too.
// - Execute-only units serve only instruction fetch; data and debug reads blocked.
// - A read completes in one clock cycle with no wait states.
module fbp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [fbp_pkg::PROT_UNITS-1:0] readOnlySet,
  input wire logic [fbp_pkg::PROT_UNITS-1:0] execOnlySet,
  input wire logic rdReq,
  input wire fbp_pkg::fbp_src_t rdSrc,
  input wire logic [fbp_pkg::ADDR_W-1:0] rdAddr,
  output logic rdValid,
  output logic rdDenied,
  output logic [31:0] rdData,
  input wire logic progReq,
  input wire logic eraseReq,
  input wire logic [fbp_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [31:0] wrData,
  output logic wrAccept,
  output logic wrDenied,
  output logic eraseBusy,
  output logic [fbp_pkg::PROT_UNITS-1:0] readOnlyMap,
  output logic [fbp_pkg::PROT_UNITS-1:0] execOnlyMap
);
  import fbp_pkg::*;

  typedef struct packed {
    logic [PROT_UNITS-1:0] ro;
    logic [PROT_UNITS-1:0] xo;
    logic rdValid;
    logic rdDenied;
    logic [31:0] rdData;
    logic wrAccept;
    logic wrDenied;
  } fbp_state_t;

  fbp_state_t st_ff;
  fbp_state_t nxt_st;
  fbp_req_if req ();

  logic [PU_IDX_W-1:0] rdUnit;
  logic [PU_IDX_W-1:0] wrUnit;
  logic rdBlocked;
  logic wrBlocked;
  logic wrAny;

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  fbp_array u_array (
    .clk(clk),
    .rst(rst),
    .req(req)
  );

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  // Upper address bits pick the 2 KB protection unit.
  assign rdUnit = rdAddr[ADDR_W-1 -: PU_IDX_W];
  assign wrUnit = wrAddr[ADDR_W-1 -: PU_IDX_W];
  assign rdBlocked = st_ff.xo[rdUnit] && (rdSrc != FBP_SRC_FETCH);
  assign wrBlocked = st_ff.ro[wrUnit] || st_ff.xo[wrUnit];
  assign wrAny = progReq || eraseReq;

  // Requests that pass protection reach the array unless it is busy erasing (an erase beats a program); blocked ones never do.
  assign req.progEn = progReq && !eraseReq && !wrBlocked && !req.busy;
  assign req.eraseEn = eraseReq && !wrBlocked && !req.busy;
  assign req.wordAddr = wrAddr[ADDR_W-1:ADDR_W-WORD_ADDR_W];
  assign req.wrData = wrData;
  assign req.rdAddr = rdAddr[ADDR_W-1:ADDR_W-WORD_ADDR_W];

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  // Protection bits only ever get set: once a unit is locked, nothing
  // short of reset unlocks it, which keeps a bad write from opening it.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ro = st_ff.ro | readOnlySet;
    nxt_st.xo = st_ff.xo | execOnlySet;
    nxt_st.rdValid = rdReq && !rdBlocked;
    nxt_st.rdDenied = rdReq && rdBlocked;
    nxt_st.rdData = '0;
    if (rdReq && !rdBlocked) begin
      nxt_st.rdData = req.rdWord;
    end
    nxt_st.wrAccept = req.progEn || req.eraseEn;
    nxt_st.wrDenied = wrAny && wrBlocked;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{ro: PROT_RESET, xo: PROT_RESET, rdValid: 1'b0, rdDenied: 1'b0,
        rdData: 32'h00000000, wrAccept: 1'b0, wrDenied: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdValid = st_ff.rdValid;
  assign rdDenied = st_ff.rdDenied;
  assign rdData = st_ff.rdData;
  assign wrAccept = st_ff.wrAccept;
  assign wrDenied = st_ff.wrDenied;
  assign eraseBusy = req.busy;
  assign readOnlyMap = st_ff.ro;
  assign execOnlyMap = st_ff.xo;

endmodule
`default_nettype wire

// ---- core/fbp_pkg.sv ----
// Package for the flash block protection logic.
// Assumes a single system clock and a synchronous active-high reset.
`default_nettype none
package fbp_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned FLASH_BYTES = 131072;
  localparam int unsigned ERASE_UNIT_BYTES = 1024;
  localparam int unsigned PROT_UNIT_BYTES = 2048;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned ADDR_W = $clog2(FLASH_BYTES);
  localparam int unsigned WORD_ADDR_W = ADDR_W - $clog2(WORD_BYTES);
  localparam int unsigned WORDS = FLASH_BYTES / WORD_BYTES;
  localparam int unsigned ERASE_UNITS = FLASH_BYTES / ERASE_UNIT_BYTES;
  localparam int unsigned PROT_UNITS = FLASH_BYTES / PROT_UNIT_BYTES;
  localparam int unsigned WORDS_PER_ERASE = ERASE_UNIT_BYTES / WORD_BYTES;
  localparam int unsigned ERASE_SHIFT = $clog2(ERASE_UNIT_BYTES);
  localparam int unsigned PROT_SHIFT = $clog2(PROT_UNIT_BYTES);
  localparam int unsigned EU_IDX_W = $clog2(ERASE_UNITS);
  localparam int unsigned PU_IDX_W = $clog2(PROT_UNITS);
  localparam int unsigned EW_IDX_W = $clog2(WORDS_PER_ERASE);

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [PROT_UNITS-1:0] PROT_RESET = '0;

  // Who is asking for a read.
  typedef enum logic [1:0] {
    FBP_SRC_FETCH,
    FBP_SRC_DATA,
    FBP_SRC_DEBUG
  } fbp_src_t;

endpackage
`default_nettype wire

// ---- core/fbp_req_if.sv ----
// Interface carrying one checked request from the top to the array.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface fbp_req_if;
  import fbp_pkg::*;
  logic progEn;
  logic eraseEn;
  logic [WORD_ADDR_W-1:0] wordAddr;
  logic [31:0] wrData;
  logic [WORD_ADDR_W-1:0] rdAddr;
  logic [31:0] rdWord;
  logic busy;
  modport ctrl (output progEn, output eraseEn, output wordAddr, output wrData,
    output rdAddr, input rdWord, input busy);
  modport array (input progEn, input eraseEn, input wordAddr, input wrData,
    input rdAddr, output rdWord, output busy);
endinterface
`default_nettype wire

// ---- core/fbp_array.sv ----
// Flash array storage: word wide flip-flops with per-unit erase.
// Assumes requests arrive already checked against protection.
`timescale 1ns/1ns
`default_nettype none
module fbp_array (
  input wire logic clk,
  input wire logic rst,
  fbp_req_if.array req
);
  import fbp_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][31:0] mem;
    logic erasing;
    logic [EU_IDX_W-1:0] eraseUnit;
    logic [EW_IDX_W-1:0] eraseWord;
  } fbp_arr_state_t;

  fbp_arr_state_t st_ff;
  fbp_arr_state_t nxt_st;

  // ----------------------------------------------------------------
  // Read path and status
  // ----------------------------------------------------------------
  // Reads are combinational so the top can register the word in one cycle.
  assign req.rdWord = st_ff.mem[req.rdAddr];
  assign req.busy = st_ff.erasing;

  // ----------------------------------------------------------------
  // Program and erase
  // ----------------------------------------------------------------
  // Erase walks one word per cycle, touching only the chosen 1 KB unit.
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.erasing) begin
      nxt_st.mem[{st_ff.eraseUnit, st_ff.eraseWord}] = ERASED_WORD;
      nxt_st.eraseWord = st_ff.eraseWord + 1'b1;
      if (&st_ff.eraseWord) begin
        nxt_st.erasing = 1'b0;
      end
    end else if (req.eraseEn) begin
      nxt_st.erasing = 1'b1;
      nxt_st.eraseUnit = req.wordAddr[WORD_ADDR_W-1 -: EU_IDX_W];
      nxt_st.eraseWord = '0;
    end else if (req.progEn) begin
      // Programming can only clear bits, as real flash cells do.
      nxt_st.mem[req.wordAddr] = st_ff.mem[req.wordAddr] & req.wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff.erasing <= 1'b0;
      st_ff.eraseUnit <= '0;
      st_ff.eraseWord <= '0;
      st_ff.mem <= st_ff.mem; // Contents are nonvolatile across reset.
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// ---- test/fbp_top_chk.sv ----
// Port checker for the flash block protection top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module fbp_top_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [63:0] readOnlySet,
  input wire logic rdReq,
  input wire fbp_pkg::fbp_src_t rdSrc,
  input wire logic [16:0] rdAddr,
  input wire logic rdValid,
  input wire logic rdDenied,
  input wire logic [31:0] rdData,
  input wire logic progReq,
  input wire logic eraseReq,
  input wire logic [16:0] wrAddr,
  input wire logic wrAccept,
  input wire logic wrDenied,
  input wire logic eraseBusy,
  input wire logic [63:0] readOnlyMap,
  input wire logic [63:0] execOnlyMap
);
  import fbp_pkg::*;
  logic wrGo;
  logic ro;
  logic xo;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A write that the design must judge; busy writes to open units are dropped silently.
  assign wrGo = (progReq | eraseReq) & ~eraseBusy;
  assign ro = readOnlyMap[wrAddr[16:11]];
  assign xo = execOnlyMap[wrAddr[16:11]];
  a_read_answer: assert property (rdReq |=> rdValid != rdDenied)
    else $error("read not answered exactly once");
  a_fetch_served: assert property (rdReq && rdSrc == FBP_SRC_FETCH |=> rdValid)
    else $error("fetch read not served");
  a_xo_block: assert property (rdReq && rdSrc != FBP_SRC_FETCH
    && execOnlyMap[rdAddr[16:11]] |=> rdDenied)
    else $error("read of execute-only unit not blocked");
  a_open_read: assert property (rdReq && !execOnlyMap[rdAddr[16:11]] |=> rdValid)
    else $error("read of open unit not served");
  a_denied_zero: assert property (rdDenied |-> rdData == 32'h00000000)
    else $error("blocked read leaks data");
  a_ro_write: assert property (wrGo && ro |=> wrDenied && !wrAccept)
    else $error("write to read-only unit not refused");
  a_xo_write: assert property (wrGo && xo |=> wrDenied && !wrAccept)
    else $error("write to execute-only unit not refused");
  a_open_write: assert property (wrGo && !ro && !xo |=> wrAccept)
    else $error("write to open unit not accepted");
  a_erase_time: assert property (wrGo && eraseReq && !ro && !xo
    |=> eraseBusy ##255 eraseBusy ##1 !eraseBusy) else $error("erase length wrong");
  a_map_sticky: assert property (1'h1 |=>
    (readOnlyMap & $past(readOnlyMap | readOnlySet)) == $past(readOnlyMap | readOnlySet))
    else $error("read-only map lost a bit");
  cover property (rdDenied);
  cover property (wrDenied);
  cover property ($fell(eraseBusy));
endmodule
bind fbp_top fbp_top_chk chk (.clk, .rst, .readOnlySet, .rdReq, .rdSrc, .rdAddr, .rdValid,
  .rdDenied, .rdData, .progReq, .eraseReq, .wrAddr, .wrAccept, .wrDenied, .eraseBusy,
  .readOnlyMap, .execOnlyMap);
`default_nettype wire

// ---- test/fbp_host.sv ----
// Requester model: fetch, data and debug reads plus program and erase.
// Assumes one request at a time, stepped from the shared clock.
`timescale 1ns/1ns
`default_nettype none
module fbp_host (
  input wire logic clk,
  output logic rdReq,
  output var fbp_pkg::fbp_src_t rdSrc,
  output logic [16:0] rdAddr,
  output logic progReq,
  output logic eraseReq,
  output logic [16:0] wrAddr,
  output logic [31:0] wrData
);
  import fbp_pkg::*;
  // Released lines show inverted values so stale data cannot pass a check.
  initial begin
    {rdReq, progReq, eraseReq, rdAddr, wrAddr, wrData} = '0;
    rdSrc = FBP_SRC_FETCH;
  end
  task automatic rd(input fbp_src_t s, input logic [16:0] a);
    @(posedge clk);
    rdReq <= 1'h1;
    rdSrc <= s;
    rdAddr <= a;
    @(posedge clk);
    // The source is flipped on release so a stale source cannot pass.
    rdReq <= 1'h0;
    rdSrc <= (s == FBP_SRC_FETCH) ? FBP_SRC_DEBUG : FBP_SRC_FETCH;
    rdAddr <= ~a;
  endtask
  task automatic wr(input logic [1:0] op, input logic [16:0] a, input logic [31:0] d);
    @(posedge clk);
    {progReq, eraseReq, wrAddr, wrData} <= {op, a, d};
    @(posedge clk);
    {progReq, eraseReq, wrAddr, wrData} <= {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- test/test_fbp_top.sv ----
// Self-checking bench for the flash block protection top.
// Assumes the requester model drives all request ports.
`timescale 1ns/1ns
`default_nettype none
module test_fbp_top;
  import fbp_pkg::*;
  typedef struct packed {fbp_src_t s; logic [16:0] a; logic v; logic [31:0] d;} fbp_row_t;
  logic clk, rst, rdReq, rdValid, rdDenied, progReq, eraseReq, wrAccept, wrDenied, eraseBusy;
  logic [63:0] readOnlySet, execOnlySet, readOnlyMap, execOnlyMap;
  fbp_src_t rdSrc;
  logic [16:0] rdAddr, wrAddr;
  logic [31:0] rdData, wrData;
  int nErrors = 0;
  int comparisons = 0;
  fbp_row_t rows [8] = '{'{FBP_SRC_FETCH, 17'h0, 1'h1, 32'hffffffff},
    '{FBP_SRC_DATA, 17'h400, 1'h1, 32'ha5a5a5a5}, '{FBP_SRC_DEBUG, 17'h403, 1'h1, 32'ha5a5a5a5},
    '{FBP_SRC_DATA, 17'h800, 1'h1, 32'h0f0f0f0f}, '{FBP_SRC_FETCH, 17'h1000, 1'h1, 32'h3c3c3c3c},
    '{FBP_SRC_FETCH, 17'h13fc, 1'h1, 32'hffffffff}, '{FBP_SRC_DEBUG, 17'h13fc, 1'h0, 32'h0},
    '{FBP_SRC_DATA, 17'h17fc, 1'h0, 32'h0}};
  fbp_top dut (.clk, .rst, .readOnlySet, .execOnlySet, .rdReq, .rdSrc, .rdAddr, .rdValid,
    .rdDenied, .rdData, .progReq, .eraseReq, .wrAddr, .wrData, .wrAccept, .wrDenied,
    .eraseBusy, .readOnlyMap, .execOnlyMap);
  fbp_host host (.clk, .rdReq, .rdSrc, .rdAddr, .progReq, .eraseReq, .wrAddr, .wrData);
  // Free-running 4 ns clock.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop();
    if (nErrors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdChk(fbp_src_t s, logic [16:0] a, logic v, logic [31:0] d);
    host.rd(s, a);
    #1 check("read", {rdValid, rdDenied, rdData}, {v, ~v, d});
  endtask
  // Op is {program, erase}; ad is the expected {accept, denied} pair.
  task automatic wrChk(logic [1:0] op, logic [16:0] a, logic [31:0] d, logic [1:0] ad);
    host.wr(op, a, d);
    #1 check("write", {wrAccept, wrDenied}, ad);
  endtask
  // Bounded wait for an erase to finish; a hang ends the run.
  task automatic waitIdle();
    for (int i = 0; i < 300 && eraseBusy !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    if (eraseBusy !== 1'h0) begin
      nErrors++;
      report_and_stop();
    end
  endtask
  // Main sequence: prepare contents, protect, then table and hand-written cases.
  initial begin
    {rst, readOnlySet, execOnlySet} = {1'h1, 128'h0};
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    #1 check("maps", readOnlyMap | execOnlyMap, 64'h0);
    for (int u = 0; u < 5; u++) begin
      wrChk(2'h1, 17'(u * 1024), 32'h0, 2'h2);
      check("busy", eraseBusy, 1'h1);
      waitIdle();
    end
    wrChk(2'h2, 17'h0, 32'h12345678, 2'h2);
    wrChk(2'h2, 17'h0, 32'hff00ffff, 2'h2);
    rdChk(FBP_SRC_DATA, 17'h0, 1'h1, 32'h12345678 & 32'hff00ffff);
    wrChk(2'h2, 17'h400, 32'ha5a5a5a5, 2'h2);
    wrChk(2'h2, 17'h800, 32'h0f0f0f0f, 2'h2);
    wrChk(2'h2, 17'h1000, 32'h3c3c3c3c, 2'h2);
    wrChk(2'h1, 17'h0, 32'h0, 2'h2);
    waitIdle();
    @(posedge clk);
    {readOnlySet, execOnlySet} <= {64'h2, 64'h4};
    @(posedge clk);
    {readOnlySet, execOnlySet} <= 128'h0;
    #1 check("roMap", readOnlyMap, 64'h2);
    check("xoMap", execOnlyMap, 64'h4);
    foreach (rows[i]) rdChk(rows[i].s, rows[i].a, rows[i].v, rows[i].d);
    wrChk(2'h2, 17'h800, 32'h0, 2'h1);
    wrChk(2'h1, 17'hc00, 32'h0, 2'h1);
    wrChk(2'h2, 17'h1000, 32'h0, 2'h1);
    wrChk(2'h1, 17'h1400, 32'h0, 2'h1);
    rdChk(FBP_SRC_DATA, 17'hc00, 1'h1, 32'hffffffff);
    rdChk(FBP_SRC_FETCH, 17'h1000, 1'h1, 32'h3c3c3c3c);
    wrChk(2'h1, 17'h1800, 32'h0, 2'h2);
    wrChk(2'h2, 17'h400, 32'h0, 2'h0);
    waitIdle();
    rdChk(FBP_SRC_DATA, 17'h400, 1'h1, 32'ha5a5a5a5);
    rdChk(FBP_SRC_DEBUG, 17'h1bfc, 1'h1, 32'hffffffff);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1 check("maps", readOnlyMap | execOnlyMap, 64'h0);
    wrChk(2'h2, 17'h800, 32'h0, 2'h2);
    rdChk(FBP_SRC_DEBUG, 17'h1000, 1'h1, 32'h3c3c3c3c);
    report_and_stop();
  end
endmodule
`default_nettype wire
